// *** rtl/pdx_pkg.sv ***
package pdx_pkg;

	// ------------------------------------------------------------
	// widths and field positions
	// ------------------------------------------------------------
	localparam int PDX_PG_W = 10;
	localparam int PDX_EA_W = 16;
	localparam int PDX_EA_PAGED_BIT = 15;
	localparam int PDX_PS_PAGE_BIT = 9;

	// ------------------------------------------------------------
	// page values at space boundaries
	// ------------------------------------------------------------
	localparam logic [PDX_PG_W-1:0] PDX_PG_ZERO = 10'h000;
	localparam logic [PDX_PG_W-1:0] PDX_PG_ONE = 10'h001;
	localparam logic [PDX_PG_W-1:0] PDX_PG_EXT_LAST = 10'h1ff;
	localparam logic [PDX_PG_W-1:0] PDX_PG_WIN_LOW = 10'h001;
	localparam logic [PDX_PG_W-1:0] PDX_PG_LSW_FIRST = 10'h200;
	localparam logic [PDX_PG_W-1:0] PDX_PG_LSW_LAST = 10'h2ff;
	localparam logic [PDX_PG_W-1:0] PDX_PG_MSB_FIRST = 10'h300;
	localparam logic [PDX_PG_W-1:0] PDX_PG_MSB_LAST = 10'h3ff;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [PDX_PG_W-1:0] PDX_RD_PAGE_RST = 10'h001;
	localparam logic [PDX_PG_W-1:0] PDX_WR_PAGE_RST = 10'h001;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		pdx_am_post,
		pdx_am_pre,
		pdx_am_offset,
		pdx_am_modulo,
		pdx_am_bitrev
	} pdx_mode_e;

	typedef struct packed {
		logic valid;
		logic write;
		pdx_mode_e mode;
		logic [PDX_EA_W-1:0] base;
		logic [PDX_EA_W-1:0] step;
	} pdx_req_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic trap;
		logic base_space;
		logic [PDX_PG_W-1:0] page;
		logic [PDX_EA_W-1:0] ea;
	} pdx_res_s;

endpackage

// *** rtl/pdx_page_step.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdx_page_step
	import pdx_pkg::*;
#(
	parameter bit IS_READ = 1'b1
) (
	input wire logic [PDX_PG_W-1:0] page_i,
	input wire logic linear_i,
	input wire logic ovf_i,
	input wire logic udf_i,
	input wire logic raw15_i,
	output logic [PDX_PG_W-1:0] page_o,
	output logic ea15_o,
	output logic drop_o
);

	// ------------------------------------------------------------
	// boundary table
	// ------------------------------------------------------------
	always_comb begin
		page_o = page_i;
		ea15_o = raw15_i;
		drop_o = 1'b0;
		if (!(ovf_i || udf_i)) begin
			ea15_o = raw15_i;
		end else if (!linear_i) begin
			ea15_o = 1'b1;
		end else if (ovf_i) begin
			if (page_i == PDX_PG_EXT_LAST) begin
				ea15_o = 1'b0;
				drop_o = 1'b1;
			end else if (IS_READ && page_i == PDX_PG_LSW_LAST) begin
				page_o = PDX_PG_MSB_FIRST;
				ea15_o = 1'b1;
			end else if (IS_READ && page_i == PDX_PG_MSB_LAST) begin
				ea15_o = 1'b0;
				drop_o = 1'b1;
			end else begin
				page_o = page_i + PDX_PG_ONE;
				ea15_o = 1'b1;
			end
		end else begin
			// write side drops out at the lowest page too, never reaching page zero
			if (page_i == PDX_PG_WIN_LOW) begin
				ea15_o = 1'b0;
				drop_o = 1'b1;
			end else if (IS_READ && page_i == PDX_PG_LSW_FIRST) begin
				ea15_o = 1'b0;
				drop_o = 1'b1;
			end else if (IS_READ && page_i == PDX_PG_MSB_FIRST) begin
				page_o = PDX_PG_LSW_LAST;
				ea15_o = 1'b1;
			end else begin
				page_o = page_i - PDX_PG_ONE;
				ea15_o = 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// *** rtl/pdx_core.sv ***
// Contract
// - separate read and write pages; reads use one, writes the other
// - raw indirect sum leaves address bit 15 clear on page crossing
// - crossing detected only for paged base, in every addressing mode
// - overflow increments page and sets address bit 15
// - underflow decrements page and sets address bit 15
// - offset, modulo, bit-reversed crossings set bit 15, keep page
// - overflow from last extended page keeps page, bit 15 cleared
// - read overflow from last lower-word page moves to first upper-byte page
// - read overflow from last upper-byte page keeps page, bit 15 cleared
// - underflow from lowest window page keeps page, bit 15 cleared
// - read underflow from first lower-word page keeps page, bit 15 cleared
// - read underflow from first upper-byte page steps to last lower-word page
// - dropped accesses land in unpaged base space below 0x8000
// - paged access with page zero raises address error trap
// - write through program memory page raises address error trap
`timescale 1ns/1ps
`default_nettype none
module pdx_core
	import pdx_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire pdx_req_s req_i,
	input wire logic pg_load_i,
	input wire logic pg_load_wr_i,
	input wire logic [PDX_PG_W-1:0] pg_load_val_i,
	output pdx_res_s res_o,
	output logic [PDX_PG_W-1:0] data_read_page_o,
	output logic [PDX_PG_W-1:0] data_write_page_o
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------
	// address arithmetic and crossing detection
	// ------------------------------------------------------------
	logic [PDX_PG_W-1:0] data_read_page_r;
	logic [PDX_PG_W-1:0] data_write_page_r;
	logic [16:0] sum;
	logic paged;
	logic linear;
	logic ovf;
	logic udf;
	logic raw15;
	logic rd_trap;
	logic wr_trap;
	logic trap;
	logic go;
	logic rd_load;
	logic wr_load;

	// a 16-bit offset crosses at most one page; only one step is taken
	assign sum = {1'b0, req_i.base} + {req_i.step[15], req_i.step};
	assign raw15 = sum[PDX_EA_PAGED_BIT];
	assign paged = req_i.base[PDX_EA_PAGED_BIT];
	assign linear = (req_i.mode == pdx_am_pre) || (req_i.mode == pdx_am_post);
	assign ovf = paged && sum[16];
	assign udf = paged && !sum[16] && !sum[15];

	assign rd_trap = !req_i.write && paged && (data_read_page_r == PDX_PG_ZERO);
	assign wr_trap = req_i.write && paged && ((data_write_page_r == PDX_PG_ZERO) ||
		data_write_page_r[PDX_PS_PAGE_BIT]);
	assign trap = rd_trap || wr_trap;
	assign go = req_i.valid && !trap;
	assign rd_load = pg_load_i && !pg_load_wr_i;
	assign wr_load = pg_load_i && pg_load_wr_i;

	// ------------------------------------------------------------
	// per-page boundary units
	// ------------------------------------------------------------
	logic [PDX_PG_W-1:0] rd_page_nxt;
	logic [PDX_PG_W-1:0] wr_page_nxt;
	logic rd_ea15;
	logic wr_ea15;
	logic rd_drop;
	logic wr_drop;

	pdx_page_step #(.IS_READ(1'b1)) u_rd_step (
		.page_i(data_read_page_r),
		.linear_i(linear),
		.ovf_i(ovf),
		.udf_i(udf),
		.raw15_i(raw15),
		.page_o(rd_page_nxt),
		.ea15_o(rd_ea15),
		.drop_o(rd_drop)
	);

	pdx_page_step #(.IS_READ(1'b0)) u_wr_step (
		.page_i(data_write_page_r),
		.linear_i(linear),
		.ovf_i(ovf),
		.udf_i(udf),
		.raw15_i(raw15),
		.page_o(wr_page_nxt),
		.ea15_o(wr_ea15),
		.drop_o(wr_drop)
	);

	// ------------------------------------------------------------
	// page registers
	// ------------------------------------------------------------
	// a software load wins over an access-driven step in the same cycle
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_read_page_r <= PDX_RD_PAGE_RST;
		end else if (rd_load) begin
			data_read_page_r <= pg_load_val_i;
		end else if (go && !req_i.write) begin
			data_read_page_r <= rd_page_nxt;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_write_page_r <= PDX_WR_PAGE_RST;
		end else if (wr_load) begin
			data_write_page_r <= pg_load_val_i;
		end else if (go && req_i.write) begin
			data_write_page_r <= wr_page_nxt;
		end
	end

	// ------------------------------------------------------------
	// result register
	// ------------------------------------------------------------
	pdx_res_s res_r;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			res_r <= '0;
		end else begin
			res_r.valid <= req_i.valid;
			res_r.write <= req_i.write;
			res_r.trap <= req_i.valid && trap;
			res_r.base_space <= req_i.valid && !trap && (req_i.write ? wr_drop : rd_drop);
			res_r.page <= req_i.write ? wr_page_nxt : rd_page_nxt;
			res_r.ea <= {(req_i.write ? wr_ea15 : rd_ea15), sum[14:0]};
		end
	end

	assign res_o = res_r;
	assign data_read_page_o = data_read_page_r;
	assign data_write_page_o = data_write_page_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic rd_ev;
	logic wr_ev;
	assign rd_ev = go && !req_i.write && !pg_load_i;
	assign wr_ev = go && req_i.write && !pg_load_i;

	property p_sep_pages;
		@(posedge mclk_i) disable iff (!rst_n)
		wr_ev |=> (data_read_page_r == $past(data_read_page_r));
	endproperty
	a_sep_pages: assert property (p_sep_pages)
		else $error("write access moved the read page");

	property p_raw_clear;
		@(posedge mclk_i) disable iff (!rst_n)
		(req_i.valid && (ovf || udf)) |-> !raw15;
	endproperty
	a_raw_clear: assert property (p_raw_clear)
		else $error("raw sum kept bit 15 on crossing");

	property p_detect_only;
		@(posedge mclk_i) disable iff (!rst_n)
		(go && !paged && !pg_load_i)
		|=> $stable(data_read_page_r) && $stable(data_write_page_r) && !res_o.base_space;
	endproperty
	a_detect_only: assert property (p_detect_only)
		else $error("crossing flagged for unpaged base");

	property p_ovf_inc;
		@(posedge mclk_i) disable iff (!rst_n)
		(rd_ev && linear && ovf && data_read_page_r != PDX_PG_EXT_LAST &&
		data_read_page_r != PDX_PG_LSW_LAST && data_read_page_r != PDX_PG_MSB_LAST)
		|=> (data_read_page_r == $past(data_read_page_r) + PDX_PG_ONE) && res_o.ea[15];
	endproperty
	a_ovf_inc: assert property (p_ovf_inc)
		else $error("overflow did not advance the page");

	property p_udf_dec;
		@(posedge mclk_i) disable iff (!rst_n)
		(wr_ev && linear && udf && data_write_page_r != PDX_PG_WIN_LOW)
		|=> (data_write_page_r == $past(data_write_page_r) - PDX_PG_ONE) && res_o.ea[15];
	endproperty
	a_udf_dec: assert property (p_udf_dec)
		else $error("underflow did not step the page back");

	property p_wrap;
		@(posedge mclk_i) disable iff (!rst_n)
		(rd_ev && !linear && (ovf || udf))
		|=> $stable(data_read_page_r) && res_o.ea[15] && !res_o.base_space;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("non-linear crossing changed page or cleared bit 15");

	property p_ext_last;
		@(posedge mclk_i) disable iff (!rst_n)
		(wr_ev && linear && ovf && data_write_page_r == PDX_PG_EXT_LAST)
		|=> data_write_page_r == PDX_PG_EXT_LAST && !res_o.ea[15];
	endproperty
	a_ext_last: assert property (p_ext_last)
		else $error("last extended page overflow misbehaved");

	property p_lsw_to_msb;
		@(posedge mclk_i) disable iff (!rst_n)
		(rd_ev && linear && ovf && data_read_page_r == PDX_PG_LSW_LAST)
		|=> data_read_page_r == PDX_PG_MSB_FIRST && res_o.ea[15];
	endproperty
	a_lsw_to_msb: assert property (p_lsw_to_msb)
		else $error("lower-word to upper-byte step missed");

	property p_msb_last;
		@(posedge mclk_i) disable iff (!rst_n)
		(rd_ev && linear && ovf && data_read_page_r == PDX_PG_MSB_LAST)
		|=> data_read_page_r == PDX_PG_MSB_LAST && !res_o.ea[15];
	endproperty
	a_msb_last: assert property (p_msb_last)
		else $error("last upper-byte overflow misbehaved");

	property p_win_low;
		@(posedge mclk_i) disable iff (!rst_n)
		(rd_ev && linear && udf && data_read_page_r == PDX_PG_WIN_LOW)
		|=> data_read_page_r == PDX_PG_WIN_LOW && !res_o.ea[15];
	endproperty
	a_win_low: assert property (p_win_low)
		else $error("lowest page underflow misbehaved");

	property p_lsw_first;
		@(posedge mclk_i) disable iff (!rst_n)
		(rd_ev && linear && udf && data_read_page_r == PDX_PG_LSW_FIRST)
		|=> data_read_page_r == PDX_PG_LSW_FIRST && !res_o.ea[15];
	endproperty
	a_lsw_first: assert property (p_lsw_first)
		else $error("first lower-word underflow misbehaved");

	property p_msb_back;
		@(posedge mclk_i) disable iff (!rst_n)
		(rd_ev && linear && udf && data_read_page_r == PDX_PG_MSB_FIRST)
		|=> data_read_page_r == PDX_PG_LSW_LAST && res_o.ea[15];
	endproperty
	a_msb_back: assert property (p_msb_back)
		else $error("upper-byte to lower-word step missed");

	property p_base_space;
		@(posedge mclk_i) disable iff (!rst_n)
		(res_o.valid && res_o.base_space) |-> (res_o.ea < 16'h8000) && !res_o.trap;
	endproperty
	a_base_space: assert property (p_base_space)
		else $error("dropped access outside base space");

	property p_trap_zero;
		@(posedge mclk_i) disable iff (!rst_n)
		(req_i.valid && !req_i.write && paged && data_read_page_r == PDX_PG_ZERO && !pg_load_i)
		|=> res_o.trap && $stable(data_read_page_r);
	endproperty
	a_trap_zero: assert property (p_trap_zero)
		else $error("page zero access did not trap");

	property p_trap_ps;
		@(posedge mclk_i) disable iff (!rst_n)
		(req_i.valid && req_i.write && paged && data_write_page_r[PDX_PS_PAGE_BIT])
		|=> res_o.trap && res_o.valid;
	endproperty
	a_trap_ps: assert property (p_trap_ps)
		else $error("program space write did not trap");

	property p_b2b;
		@(posedge mclk_i) disable iff (!rst_n)
		(res_o.valid && !res_o.trap && !$past(pg_load_i))
		|-> res_o.page == (res_o.write ? data_write_page_r : data_read_page_r);
	endproperty
	a_b2b: assert property (p_b2b)
		else $error("page register lags the finished access");

	c_lsw_to_msb: cover property (@(posedge mclk_i) disable iff (!rst_n)
		rd_ev && linear && ovf && data_read_page_r == PDX_PG_LSW_LAST);
	c_ext_drop: cover property (@(posedge mclk_i) disable iff (!rst_n)
		res_o.valid && res_o.base_space && res_o.write);
	c_trap: cover property (@(posedge mclk_i) disable iff (!rst_n)
		res_o.valid && res_o.trap);
	c_wrap: cover property (@(posedge mclk_i) disable iff (!rst_n)
		go && !linear && (ovf || udf));

endmodule
`default_nettype wire

// *** dv/pdx_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdx_cpu_model
	import pdx_pkg::*;
(
	input wire logic mclk_i,
	output var pdx_req_s req_o
);
	// ------------------------------------------------------------
	// address unit side: one request per held cycle
	// ------------------------------------------------------------
	initial begin
		req_o = '0;
	end

	// steps stay small so page crossing stays one page at most
	task automatic access(input logic w, input pdx_mode_e m, input logic [15:0] b, input logic [15:0] s,
			input int n);
		@(negedge mclk_i);
		req_o.valid = 1'b1;
		req_o.write = w;
		req_o.mode = m;
		req_o.base = b;
		req_o.step = s;
		repeat (n) @(negedge mclk_i);
		// released write, base and step show the inverse so stale values cannot pass as held; mode is kept
		req_o.valid = 1'b0;
		req_o.write = ~w;
		req_o.base = ~b;
		req_o.step = ~s;
	endtask
endmodule
`default_nettype wire

// *** dv/pdx_core_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdx_core_bench
	import pdx_pkg::*;
;
	typedef struct packed {
		logic w;
		pdx_mode_e mode;
		logic [9:0] pg;
		logic [15:0] base;
		logic [15:0] step;
		logic [15:0] ea;
		logic [9:0] pga;
		logic drop;
		logic trap;
		logic ckea;
	} pdx_row_s;

	logic mclk_i;
	logic rstn_i;
	pdx_req_s req_i;
	logic pg_load_i;
	logic pg_load_wr_i;
	logic [9:0] pg_load_val_i;
	pdx_res_s res_o;
	logic [9:0] rd_pg;
	logic [9:0] wr_pg;
	int failures = 0;
	int total_checks = 0;

	// ------------------------------------------------------------
	// ordinary cases: page before, request, expected result
	// ------------------------------------------------------------
	localparam pdx_row_s ROWS [21] = '{
		'{1'b0, pdx_am_pre, 10'h005, 16'hfffe, 16'h0002, 16'h8000, 10'h006, 1'b0, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h005, 16'h8000, 16'hfffe, 16'hfffe, 10'h004, 1'b0, 1'b0, 1'b1},
		'{1'b1, pdx_am_pre, 10'h010, 16'hfffe, 16'h0002, 16'h8000, 10'h011, 1'b0, 1'b0, 1'b1},
		'{1'b1, pdx_am_pre, 10'h010, 16'h8000, 16'hfffe, 16'hfffe, 10'h00f, 1'b0, 1'b0, 1'b1},
		'{1'b1, pdx_am_pre, 10'h001, 16'h8000, 16'hfffe, 16'h7ffe, 10'h001, 1'b1, 1'b0, 1'b1},
		'{1'b0, pdx_am_post, 10'h005, 16'hfffe, 16'h0002, 16'h0000, 10'h006, 1'b0, 1'b0, 1'b0},
		'{1'b0, pdx_am_offset, 10'h005, 16'hfffe, 16'h0004, 16'h8002, 10'h005, 1'b0, 1'b0, 1'b1},
		'{1'b0, pdx_am_modulo, 10'h005, 16'h8000, 16'hfffe, 16'hfffe, 10'h005, 1'b0, 1'b0, 1'b1},
		'{1'b1, pdx_am_bitrev, 10'h010, 16'hfffe, 16'h0002, 16'h8000, 10'h010, 1'b0, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h1ff, 16'hfffe, 16'h0002, 16'h0000, 10'h1ff, 1'b1, 1'b0, 1'b1},
		'{1'b1, pdx_am_pre, 10'h1ff, 16'hfffe, 16'h0002, 16'h0000, 10'h1ff, 1'b1, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h2ff, 16'hfffe, 16'h0002, 16'h8000, 10'h300, 1'b0, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h3ff, 16'hfffe, 16'h0002, 16'h0000, 10'h3ff, 1'b1, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h001, 16'h8000, 16'hfffe, 16'h7ffe, 10'h001, 1'b1, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h200, 16'h8000, 16'hfffe, 16'h7ffe, 10'h200, 1'b1, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h300, 16'h8000, 16'hfffe, 16'hfffe, 10'h2ff, 1'b0, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h005, 16'h7ffe, 16'h0004, 16'h8002, 10'h005, 1'b0, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h005, 16'h9000, 16'h0002, 16'h9002, 10'h005, 1'b0, 1'b0, 1'b1},
		'{1'b0, pdx_am_pre, 10'h000, 16'h8000, 16'h0002, 16'h0000, 10'h000, 1'b0, 1'b1, 1'b0},
		'{1'b1, pdx_am_pre, 10'h200, 16'h9000, 16'h0002, 16'h0000, 10'h200, 1'b0, 1'b1, 1'b0},
		'{1'b1, pdx_am_pre, 10'h000, 16'h9000, 16'h0002, 16'h0000, 10'h000, 1'b0, 1'b1, 1'b0}
	};

	pdx_core uut (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.req_i(req_i),
		.pg_load_i(pg_load_i),
		.pg_load_wr_i(pg_load_wr_i),
		.pg_load_val_i(pg_load_val_i),
		.res_o(res_o),
		.data_read_page_o(rd_pg),
		.data_write_page_o(wr_pg)
	);

	pdx_cpu_model cpu (
		.mclk_i(mclk_i),
		.req_o(req_i)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic load_page(input logic w, input logic [9:0] v);
		@(negedge mclk_i);
		pg_load_i = 1'b1;
		pg_load_wr_i = w;
		pg_load_val_i = v;
		@(negedge mclk_i);
		pg_load_i = 1'b0;
	endtask

	task automatic stop_test();
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	// generous: the whole run is about 120 cycles, the limit 4000
	initial begin
		#20000;
		failures++;
		stop_test();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		pdx_row_s r;
		rstn_i = 1'b0;
		pg_load_i = 1'b0;
		pg_load_wr_i = 1'b0;
		pg_load_val_i = 10'h000;
		repeat (8) @(negedge mclk_i);
		check(16'(res_o), 16'h0000, "result in reset");
		check(16'(res_o >> 16), 16'h0000, "result flags in reset");
		check(16'(rd_pg), 16'h0001, "read page in reset");
		check(16'(wr_pg), 16'h0001, "write page in reset");
		rstn_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		foreach (ROWS[i]) begin
			r = ROWS[i];
			load_page(r.w, r.pg);
			cpu.access(r.w, r.mode, r.base, r.step, 1);
			check(16'(res_o.valid), 16'h0001, "valid");
			check(16'(res_o.write), 16'(r.w), "write copy");
			check(16'(res_o.trap), 16'(r.trap), "trap");
			check(16'(r.w ? wr_pg : rd_pg), 16'(r.pga), "page reg");
			if (!r.trap) begin
				check(16'(res_o.base_space), 16'(r.drop), "drop");
				check(16'(res_o.page), 16'(r.pga), "page");
			end
			if (r.ckea) begin
				check(res_o.ea, r.ea, "address");
			end
		end
		// write step must leave the read page alone
		load_page(1'b0, 10'h005);
		load_page(1'b1, 10'h010);
		cpu.access(1'b1, pdx_am_pre, 16'hfffe, 16'h0002, 1);
		check(16'(wr_pg), 16'h0011, "write page step");
		check(16'(rd_pg), 16'h0005, "read page kept");
		// back to back: second access must see the first step
		load_page(1'b0, 10'h005);
		cpu.access(1'b0, pdx_am_pre, 16'hfffe, 16'h0002, 2);
		check(16'(res_o.page), 16'h0007, "second step page");
		check(res_o.ea, 16'h8000, "second step address");
		// a load beats a step on the same register
		fork
			load_page(1'b0, 10'h050);
			cpu.access(1'b0, pdx_am_pre, 16'hfffe, 16'h0002, 1);
		join
		check(16'(rd_pg), 16'h0050, "load over step");
		// reset in mid-run acts at once
		rstn_i = 1'b0;
		#1;
		check(16'(rd_pg), 16'h0001, "read page mid reset");
		check(16'(wr_pg), 16'h0001, "write page mid reset");
		check(16'(res_o.valid), 16'h0000, "valid mid reset");
		check(16'(res_o >> 16), 16'h0000, "result flags mid reset");
		@(negedge mclk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		// first access after release starts from the reset page
		cpu.access(1'b0, pdx_am_pre, 16'hfffe, 16'h0002, 1);
		check(16'(rd_pg), 16'h0002, "step after reset");
		check(res_o.ea, 16'h8000, "address after reset");
		stop_test();
	end
endmodule
`default_nettype wire
